// ===== pkg/pacc_pkg.sv
// Purpose: Shared constants for the PWM and capture counter block
// Assumes: Module clock of 200 MHz, reference rate of 27 MHz
// Notes:   Reference rate is made by a fractional accumulator
package pacc_pkg;
	localparam int          SYS_CLK_KHZ  = 200000;
	localparam int          REF_CLK_KHZ  = 27000;
	localparam int          ACC_W        = 18;
	localparam logic [17:0] ACC_STEP     = 18'(REF_CLK_KHZ);
	localparam logic [17:0] ACC_WRAP     = 18'(SYS_CLK_KHZ);
	localparam int          PWM_W        = 8;
	localparam int          PWM_PRE_W    = 4;
	localparam int          NCH          = 4;
	localparam int          CNT_W        = 32;
	localparam int          CNT_PRE_W    = 5;
	localparam logic [1:0]  CNT_BASE_DIV = 2'h3;
	localparam logic [1:0]  EDGE_RISE    = 2'h1;
	localparam logic [1:0]  EDGE_FALL    = 2'h2;
	localparam int          IRQ_N        = 9;
	localparam int          IRQ_CAP0     = 0;
	localparam int          IRQ_CMP0     = 4;
	localparam int          IRQ_OVF      = 8;
endpackage

// ===== pkg/pacc_pwm_if.sv
// Purpose: Carrier between the top level and the PWM generator
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle strobe at the reference rate
`timescale 1ns/1ps
interface pacc_pwm_if;
	import pacc_pkg::*;
	logic                         ref_tick;
	logic                         enable;
	logic [PWM_PRE_W-1:0]         presc;
	logic [NCH-1:0][PWM_W-1:0]    duty;
	logic [NCH-1:0]               pulse;
	logic                         ovf;
	modport ctrl (output ref_tick, enable, presc, duty, input pulse, ovf);
	modport gen  (input ref_tick, enable, presc, duty, output pulse, ovf);
endinterface

// ===== hdl/pacc_pwm.sv
// Purpose: Four-channel PWM on one shared prescaled 8-bit counter
// Assumes: Reference tick supplied by the parent
// Notes:   Duty 0 keeps the output high all period
`timescale 1ns/1ps
module pacc_pwm
	import pacc_pkg::*;
(
	input  wire logic CLK_IN,
	input  wire logic RST_N_IN,
	pacc_pwm_if.gen   pif
);
	logic [PWM_PRE_W-1:0] pre_ff;
	logic [PWM_W-1:0]     cnt_ff;
	logic [NCH-1:0]       pulse_ff;
	logic                 ovf_ff;
	wire                  pre_done = (pre_ff == pif.presc);
	wire                  cnt_tick = pif.enable & pif.ref_tick & pre_done;
	wire                  cnt_wrap = cnt_tick & (cnt_ff == '1);
	wire [PWM_W-1:0]      nxt_cnt  = cnt_ff + 1'b1;

	// Divide reference by presc+1, giving 1 to 16
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pre_ff <= '0;
			cnt_ff <= '0;
			ovf_ff <= 1'b0;
		end else begin
			if (!pif.enable || (pif.ref_tick && pre_done))
				pre_ff <= '0;
			else if (pif.ref_tick)
				pre_ff <= pre_ff + 1'b1;
			if (!pif.enable)
				cnt_ff <= '0;
			else if (cnt_tick)
				cnt_ff <= nxt_cnt;
			ovf_ff <= cnt_wrap;
		end
	end

	// All channels share one counter, so periods stay aligned
	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN)
					pulse_ff[i] <= 1'b1;
				else if (!pif.enable || cnt_wrap)
					pulse_ff[i] <= 1'b1;
				else if (cnt_tick && nxt_cnt == pif.duty[i])
					pulse_ff[i] <= 1'b0;
			end
		end
	endgenerate

	assign pif.pulse = pulse_ff;
	assign pif.ovf   = ovf_ff;
endmodule

// ===== hdl/pacc_top.sv
// Purpose: PWM generator plus 32-bit capture/compare counter
// Assumes: 200 MHz module clock, control bits arrive as plain ports
// Notes:   Counter base rate is the 27 MHz reference divided by 4
`timescale 1ns/1ps
module pacc_top
	import pacc_pkg::*;
(
	input  wire logic                 CLK_IN,
	input  wire logic                 RST_N_IN,
	input  wire logic                 PWM_EN_IN,
	input  wire logic [PWM_PRE_W-1:0] PWM_PRESC_IN,
	input  wire logic [NCH*PWM_W-1:0] PWM_DUTY_IN,
	output logic      [NCH-1:0]       PULSE_OUT_CH_OUT,
	output logic                      PWM_OVF_IRQ_OUT,
	input  wire logic                 CNT_RUN_IN,
	input  wire logic [CNT_PRE_W-1:0] CNT_PRESC_IN,
	input  wire logic [CNT_W-1:0]     CNT_INIT_IN,
	input  wire logic                 CNT_WR_IN,
	input  wire logic [CNT_W-1:0]     CNT_WDATA_IN,
	output logic      [CNT_W-1:0]     CNT_VALUE_OUT,
	input  wire logic [NCH*CNT_W-1:0] CMP_VALUE_IN,
	input  wire logic [2*NCH-1:0]     CAP_EDGE_IN,
	input  wire logic [NCH-1:0]       CAPTURE_INPUT_CH_IN,
	input  wire logic [NCH-1:0]       CAP_CLR_IN,
	output logic      [NCH*CNT_W-1:0] CAP_VALUE_OUT,
	input  wire logic [IRQ_N-1:0]     IRQ_EN_IN,
	input  wire logic [IRQ_N-1:0]     IRQ_CLR_IN,
	output logic      [IRQ_N-1:0]     IRQ_PEND_OUT,
	output logic                      CNT_IRQ_OUT
);
	pacc_pwm_if pif ();

	// Fractional accumulator gives average 27 MHz strobe
	// Trade-off: strobe spacing jitters by one clock, but the
	// long-run rate is exact and no second clock domain is needed
	logic [ACC_W-1:0] acc_ff;
	logic             ref_tick_ff;
	wire  [ACC_W-1:0] acc_sum  = acc_ff + ACC_STEP;
	wire              acc_over = (acc_sum >= ACC_WRAP);
	wire  [ACC_W-1:0] nxt_acc  = acc_over ? acc_sum - ACC_WRAP : acc_sum;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			acc_ff      <= '0;
			ref_tick_ff <= 1'b0;
		end else begin
			acc_ff      <= nxt_acc;
			ref_tick_ff <= acc_over;
		end
	end

	// PWM generator hookup
	assign pif.ref_tick = ref_tick_ff;
	assign pif.enable   = PWM_EN_IN;
	assign pif.presc    = PWM_PRESC_IN;
	assign pif.duty     = PWM_DUTY_IN;
	assign PULSE_OUT_CH_OUT = pif.pulse;
	assign PWM_OVF_IRQ_OUT  = pif.ovf;

	pacc_pwm u_pwm (
		.CLK_IN   (CLK_IN),
		.RST_N_IN (RST_N_IN),
		.pif      (pif.gen)
	);

	// Base divide by four, then prescale by presc+1
	logic [1:0]           base_ff;
	logic [CNT_PRE_W-1:0] cpre_ff;
	logic [CNT_W-1:0]     cnt_ff;
	logic                 tick_d_ff;
	wire                  base_tick = ref_tick_ff & (base_ff == CNT_BASE_DIV);
	wire                  cpre_done = (cpre_ff == CNT_PRESC_IN);
	wire                  cnt_tick  = CNT_RUN_IN & base_tick & cpre_done;
	wire                  cnt_ovf   = cnt_tick & (cnt_ff == '1);

	// Base divider; restarts from zero whenever the counter is stopped
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			base_ff <= '0;
		else if (!CNT_RUN_IN)
			base_ff <= '0;
		else if (ref_tick_ff)
			base_ff <= base_ff + 1'b1;
	end

	// Prescaler divides the base rate by CNT_PRESC_IN plus one
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			cpre_ff <= '0;
		else if (!CNT_RUN_IN || (base_tick && cpre_done))
			cpre_ff <= '0;
		else if (base_tick)
			cpre_ff <= cpre_ff + 1'b1;
	end

	// Counter load, count and reload; writes ignored while running
	wire stopped_wr = CNT_WR_IN & ~CNT_RUN_IN;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			cnt_ff <= '0;
		else if (stopped_wr)
			cnt_ff <= CNT_WDATA_IN;
		else if (cnt_ovf)
			cnt_ff <= CNT_INIT_IN;
		else if (cnt_tick)
			cnt_ff <= cnt_ff + 1'b1;
	end

	// Marks a freshly changed count, so a compare fires only once
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			tick_d_ff <= 1'b0;
		else
			tick_d_ff <= cnt_tick | stopped_wr;
	end

	// Loading the start value is a stopped write of CNT_WDATA_IN
	assign CNT_VALUE_OUT = cnt_ff;

	// Capture path; stage one feeds only stage two
	logic [NCH-1:0] sync1_ff;
	logic [NCH-1:0] sync2_ff;
	logic [NCH-1:0] prev_ff;
	logic [NCH-1:0] cap_evt;
	logic [NCH-1:0] cmp_evt;
	logic [CNT_W-1:0] cap_ff [NCH];

	// Two stages before any logic looks at the pins
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= CAPTURE_INPUT_CH_IN;
			sync2_ff <= sync1_ff;
		end
	end

	// Last settled level; reset matches an idle-low pin, so no
	// false edge follows reset. Pulses under one clock may be lost.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			prev_ff <= '0;
		else
			prev_ff <= sync2_ff;
	end

	// Edge select decode, shared by all capture channels
	function automatic logic edge_hit(
		input logic [1:0] sel,
		input logic       rise,
		input logic       fall
	);
		return (|(sel & EDGE_RISE) & rise) | (|(sel & EDGE_FALL) & fall);
	endfunction

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_cc
			wire [1:0] sel  = CAP_EDGE_IN[2*i +: 2];
			wire       rise = sync2_ff[i] & ~prev_ff[i];
			wire       fall = ~sync2_ff[i] & prev_ff[i];
			wire [CNT_W-1:0] cmpv = CMP_VALUE_IN[CNT_W*i +: CNT_W];
			// Edge select: 01 rising, 10 falling, 11 both, 00 off
			assign cap_evt[i] = edge_hit(sel, rise, fall);
			// Match once per counter value, not every cycle
			assign cmp_evt[i] = tick_d_ff & CNT_RUN_IN &
			                    (cnt_ff == cmpv);

			always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN)
					cap_ff[i] <= '0;
				else if (cap_evt[i])
					cap_ff[i] <= cnt_ff;
				else if (CAP_CLR_IN[i])
					cap_ff[i] <= '0;
			end
			// Read-only view for software
			assign CAP_VALUE_OUT[CNT_W*i +: CNT_W] = cap_ff[i];
		end
	endgenerate

	// Pending flags: a new event beats a clear in the same cycle
	logic [IRQ_N-1:0] pend_ff;
	wire  [IRQ_N-1:0] irq_set;
	wire  [IRQ_N-1:0] nxt_pend = irq_set | (pend_ff & ~IRQ_CLR_IN);

	// Source order: captures, then compares, then counter overflow
	assign irq_set[IRQ_CAP0 +: NCH] = cap_evt;
	assign irq_set[IRQ_CMP0 +: NCH] = cmp_evt;
	assign irq_set[IRQ_OVF]         = cnt_ovf;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			pend_ff <= '0;
		else
			pend_ff <= nxt_pend;
	end

	assign IRQ_PEND_OUT = pend_ff;
	assign CNT_IRQ_OUT  = |(pend_ff & IRQ_EN_IN);
endmodule

// ===== dv/pacc_top_properties.sv
// Purpose: Port-level assertions for the PWM and capture counter
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to pacc_top from the bench top file
`timescale 1ns/1ps
module pacc_props
	import pacc_pkg::*;
(
	input wire logic             CLK_IN,
	input wire logic             RST_N_IN,
	input wire logic [NCH-1:0]   PULSE_OUT_CH_OUT,
	input wire logic             PWM_OVF_IRQ_OUT,
	input wire logic             CNT_RUN_IN,
	input wire logic             CNT_WR_IN,
	input wire logic [CNT_W-1:0] CNT_WDATA_IN,
	input wire logic [CNT_W-1:0] CNT_VALUE_OUT,
	input wire logic [CNT_W-1:0] CNT_INIT_IN,
	input wire logic [IRQ_N-1:0] IRQ_EN_IN,
	input wire logic [IRQ_N-1:0] IRQ_CLR_IN,
	input wire logic [IRQ_N-1:0] IRQ_PEND_OUT,
	input wire logic             CNT_IRQ_OUT
);
	// All checks sample on the module clock
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Wrap step: all ones followed by the reload value
	sequence s_wrap; $past(CNT_VALUE_OUT) == '1 && !$past(CNT_WR_IN)
		&& CNT_VALUE_OUT == $past(CNT_INIT_IN); endsequence
	sequence s_stop_wr; CNT_WR_IN && !CNT_RUN_IN; endsequence
	property p_wr; s_stop_wr |=> CNT_VALUE_OUT == $past(CNT_WDATA_IN);
	endproperty
	a_wr: assert property (p_wr) else $error("stopped write lost");
	property p_stop; !CNT_RUN_IN && !CNT_WR_IN |=> $stable(CNT_VALUE_OUT);
	endproperty
	a_stop: assert property (p_stop) else $error("count moved");
	// Only a write may jump the count; stepping is +1 or reload
	property p_step; $changed(CNT_VALUE_OUT) && !$past(CNT_WR_IN) |->
		CNT_VALUE_OUT == $past(CNT_VALUE_OUT) + 32'h1
		|| CNT_VALUE_OUT == $past(CNT_INIT_IN); endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_ovf; s_wrap |-> ##[0:1] IRQ_PEND_OUT[IRQ_OVF]; endproperty
	a_ovf: assert property (p_ovf) else $error("no ovf flag");
	property p_pulse; PWM_OVF_IRQ_OUT |=> !PWM_OVF_IRQ_OUT; endproperty
	a_pulse: assert property (p_pulse) else $error("long ovf");
	property p_wrap; PWM_OVF_IRQ_OUT |-> ##[0:1] PULSE_OUT_CH_OUT == '1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("low at wrap");
	property p_irq; CNT_IRQ_OUT == |(IRQ_PEND_OUT & IRQ_EN_IN); endproperty
	a_irq: assert property (p_irq) else $error("irq line");
	// A flag may drop only after its clear bit was seen
	property p_sticky; ($past(IRQ_PEND_OUT) & ~IRQ_PEND_OUT
		& ~$past(IRQ_CLR_IN)) == '0; endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule

// ===== dv/pacc_pins.sv
// Purpose: Pin-side model: capture event sources and port bits
// Assumes: Events have no phase relation to the module clock
// Notes:   Edges lag the request by a fraction of a cycle
`timescale 1ns/1ps
module pacc_pins
	import pacc_pkg::*;
(
	input  wire logic [NCH-1:0] pulse_in,
	input  wire logic [NCH-1:0] lvl_in,
	output logic      [NCH-1:0] port_a_out,
	output logic      [NCH-1:0] cap_out
);
	// Pulse outputs routed as push-pull alternate outputs
	assign port_a_out = pulse_in;
	// Off-grid delay exercises the input synchroniser
	initial cap_out = '0;
	always @(lvl_in) cap_out <= #1.3 lvl_in;
endmodule

// ===== dv/pwm_and_capture_counter_tb.sv
// Purpose: Self-checking bench for the PWM and capture counter
// Assumes: 200 MHz clock, 27 MHz strobe averaged inside the block
// Notes:   Rates are checked with a tolerance for strobe jitter
`timescale 1ns/1ps
module pwm_and_capture_counter_tb;
	import pacc_pkg::*;
	logic         clk, rst_n, pwm_en, run, wr, ovf, irq;
	logic [3:0]   pre, clr, lvl, pin, pulse, port_a, e_pnd;
	logic [4:0]   cpre;
	logic [7:0]   edg;
	logic [8:0]   ien, iclr, pend;
	logic [31:0]  init, wd, val, duty, lf, m_cnt, b;
	logic [127:0] cmp, cap;
	logic [31:0]  e_cap [4];
	int           num_errors, checks_done, cyc, per, i, s, e;
	int           hi [4];
	pacc_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PWM_EN_IN(pwm_en),
		.PWM_PRESC_IN(pre), .PWM_DUTY_IN(duty), .PULSE_OUT_CH_OUT(pulse),
		.PWM_OVF_IRQ_OUT(ovf), .CNT_RUN_IN(run), .CNT_PRESC_IN(cpre),
		.CNT_INIT_IN(init), .CNT_WR_IN(wr), .CNT_WDATA_IN(wd),
		.CNT_VALUE_OUT(val), .CMP_VALUE_IN(cmp), .CAP_EDGE_IN(edg),
		.CAPTURE_INPUT_CH_IN(pin), .CAP_CLR_IN(clr), .CAP_VALUE_OUT(cap),
		.IRQ_EN_IN(ien), .IRQ_CLR_IN(iclr), .IRQ_PEND_OUT(pend),
		.CNT_IRQ_OUT(irq));
	pacc_pins u_pins (.pulse_in(pulse), .lvl_in(lvl), .port_a_out(port_a),
		.cap_out(pin));
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] y);
		checks_done++;
		if (y !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	endtask
	// Counter write; the model follows only while stopped
	task automatic cw(input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		if (run !== 1'b1) m_cnt = d;
	endtask
	task automatic stop_clr;
		@(posedge clk);
		run <= 1'b0;
		iclr <= '1;
		@(posedge clk);
		iclr <= '0;
		#1 chk("pend clear", 0, pend);
	endtask
	task automatic end_of_test;
		$display("Errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Cycle ceiling so a hung wait still reaches the report
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		{rst_n, pwm_en, run, wr, pre, clr, lvl, cpre, edg} = '0;
		{ien, iclr, init, wd, duty, cmp} = '0;
		{num_errors, checks_done, cyc} = '0;
		lf = 32'h597C7FE5;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("reset pulse", 32'hF, pulse);
		chk("reset pend", 0, pend);
		// Stopped write, count rate, then a refused write while running
		lf = nx(lf);
		cw(lf);
		#1 chk("cnt write", m_cnt, val);
		@(posedge clk);
		cpre <= 5'(lf[1:0]);
		run <= 1'b1;
		repeat (2000) @(posedge clk);
		#1 e = 270 / (4 * (lf[1:0] + 1));
		chk("cnt rate", 1, int'(val - m_cnt) inside {[e - 1:e + 1]});
		lf = nx(lf);
		cw(lf);
		#1 chk("run write", 0, val === lf);
		// Wrap reloads the initial value and flags overflow
		@(posedge clk);
		run <= 1'b0;
		init <= nx(lf) & 32'h7FFFFFFF;
		ien <= 9'h100;
		cw(32'hFFFFFFFE);
		run <= 1'b1;
		cpre <= 5'h0;
		for (i = 0; i < 999 && val !== init; i++) @(negedge clk);
		chk("reload", init, val);
		chk("ovf pend", 9'h100, pend);
		chk("irq on", 1, irq);
		stop_clr();
		// Four compares on consecutive counts; line stays masked
		b = nx(init) & 32'h7FFFFFFF;
		cw(b);
		cmp <= {b + 32'h4, b + 32'h3, b + 32'h2, b + 32'h1};
		run <= 1'b1;
		for (i = 0; i < 999 && val !== b + 32'h5; i++) @(negedge clk);
		chk("cmp pend", 9'h0F0, pend);
		chk("irq off", 0, irq);
		stop_clr();
		// Rise then fall; channels set to rise, fall, both, off
		@(posedge clk);
		edg <= 8'h39;
		ien <= 9'h00F;
		e_pnd = 4'h0;
		e_cap = '{default: '0};
		for (s = 0; s < 2; s++) begin
			lf = nx(lf);
			cw(lf);
			lvl <= s ? 4'h0 : 4'hF;
			repeat (5) @(posedge clk);
			#1;
			for (i = 0; i < 4; i++) begin
				if (edg[2 * i + s]) begin
					e_cap[i] = m_cnt;
					e_pnd[i] = 1'b1;
				end
				chk("capture", e_cap[i], cap[32 * i +: 32]);
			end
			chk("cap pend", e_pnd, pend);
			chk("cap irq", 1, irq);
		end
		@(posedge clk);
		clr <= 4'hF;
		@(posedge clk);
		clr <= 4'h0;
		stop_clr();
		chk("cap clear", 0, |cap);
		// One PWM period: length and high time of each channel
		@(posedge clk);
		lf = nx(lf);
		pre <= 4'(lf[1:0]);
		duty <= {8'h00, lf[23:0]};
		pwm_en <= 1'b1;
		for (i = 0; i < 9999 && ovf !== 1'b1; i++) @(negedge clk);
		per = 0;
		hi = '{default: 0};
		do begin
			@(negedge clk);
			per++;
			for (i = 0; i < 4; i++) hi[i] += port_a[i];
		end while (ovf !== 1'b1 && per < 9999);
		e = 256 * (lf[1:0] + 1) * 200 / 27;
		chk("pwm period", 1, per inside {[e - 12:e + 12]});
		for (i = 0; i < 4; i++) begin
			e = duty[8 * i +: 8] * (lf[1:0] + 1) * 200 / 27;
			if (duty[8 * i +: 8] == 8'h00) e = per;
			chk("pwm high", 1, hi[i] inside {[e - 16:e + 16]});
		end
		end_of_test();
	end
endmodule
bind pacc_top pacc_props u_props (.CLK_IN, .RST_N_IN, .PULSE_OUT_CH_OUT,
	.PWM_OVF_IRQ_OUT, .CNT_RUN_IN, .CNT_WR_IN, .CNT_WDATA_IN,
	.CNT_VALUE_OUT, .CNT_INIT_IN, .IRQ_EN_IN, .IRQ_CLR_IN, .IRQ_PEND_OUT,
	.CNT_IRQ_OUT);
